// File: core/vcres_defines.svh
`ifndef VCRES_DEFINES_SVH
`define VCRES_DEFINES_SVH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define VCRES_CAP_OFFSET        12'h150
`define VCRES_CTL_OFFSET        12'h154
`define VCRES_STS_OFFSET        12'h158

// ------------------------------------------------------------
// capability fields
// ------------------------------------------------------------
`define VCRES_ARB_CAP_RESET     8'h09
`define VCRES_TIME_SLOTS_RESET  7'h7f
`define VCRES_TABLE_OFS_RESET   8'h04
`define VCRES_CAP_SLOTS_LSB     16
`define VCRES_CAP_OFS_LSB       24
`define VCRES_CAP_APS_BIT       14
`define VCRES_CAP_SNOOP_BIT     15

// ------------------------------------------------------------
// control fields
// ------------------------------------------------------------
`define VCRES_MAP_RESET         8'hff
`define VCRES_CTL_LOAD_BIT      16
`define VCRES_CTL_SEL_LSB       17
`define VCRES_CTL_ID_LSB        24
`define VCRES_CTL_EN_BIT        31
`define VCRES_CHANNEL_ID        3'h0
`define VCRES_ENABLE_RESET      1'b1

// ------------------------------------------------------------
// status fields
// ------------------------------------------------------------
`define VCRES_STS_TABLE_BIT     16
`define VCRES_STS_NEG_BIT       17

`endif

// File: core/vcres_pkg.sv
package vcres_pkg;
    typedef enum logic [2:0] {
        VCRES_ARB_HW_FIXED = 3'h0,
        VCRES_ARB_WRR128   = 3'h3
    } vcres_arb_sel_e;
    typedef logic [31:0] vcres_word_t;
    typedef logic [11:0] vcres_addr_t;
endpackage

// File: core/vcres_sel_filter.sv
`timescale 1ns/100ps
module vcres_sel_filter
    import vcres_pkg::*;
(
    input  wire logic [2:0]     sel_in,
    output vcres_arb_sel_e      sel_out
);
    import vcres_pkg::*;

    // ------------------------------------------------------------
    // legal scheme filter
    // ------------------------------------------------------------
    always_comb begin
        unique case (sel_in)
            3'h3:    sel_out = VCRES_ARB_WRR128;
            default: sel_out = VCRES_ARB_HW_FIXED;
        endcase
    end
endmodule

// File: core/vcres_table_tracker.sv
`timescale 1ns/100ps
module vcres_table_tracker (
    input  wire logic clk_sys,
    input  wire logic nrst,
    input  wire logic table_entry_wr,
    input  wire logic load_pulse,
    input  wire logic load_done,
    output logic      table_status,
    output logic      load_busy
);
    typedef enum {VCRES_IDLE, VCRES_LOADING} vcres_load_e;
    vcres_load_e state_reg, state_next;
    logic        status_reg, status_next;

    // ------------------------------------------------------------
    // status and load sequence
    // ------------------------------------------------------------
    always_comb begin
        state_next  = state_reg;
        status_next = status_reg;
        unique case (state_reg)
            VCRES_IDLE: begin
                if (load_pulse) begin
                    state_next = VCRES_LOADING;
                end
            end
            VCRES_LOADING: begin
                if (load_done) begin
                    state_next  = VCRES_IDLE;
                    status_next = 1'b0;
                end
            end
        endcase
        if (table_entry_wr) begin
            status_next = 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            state_reg  <= VCRES_IDLE;
            status_reg <= 1'b0;
        end else begin
            state_reg  <= state_next;
            status_reg <= status_next;
        end
    end

    assign table_status = status_reg;
    assign load_busy    = (state_reg == VCRES_LOADING);
endmodule

// File: core/vcres_regs.sv
`timescale 1ns/100ps
`include "vcres_defines.svh"
// Behaviour
// - capability bits 7:0 read 09h: fixed and weighted round-robin (128) arbitration.
// - time-based weighted arbitration is not a legal choice on this channel.
// - capability bit 14 reads zero.
// - capability bit 15 reads zero.
// - capability bits 22:16 give time slots minus one, reset 7fh.
// - capability bits 31:24 give table zero offset in 16-byte units, 04h.
// - control bits 7:0 hold the read-write class map, reset ffh.
// - the class map default can be replaced by management or eeprom load.
// - writing one to control bit 16 applies the table; it reads zero.
// - select bits 19:17 keep 000b or 011b; anything else becomes 000b.
// - control bits 26:24 read a fixed channel identifier 000b.
// - control bit 31 enables the channel, reset one.
// - status bit 16 sets on any table entry write.
// - status bit 16 clears only when a requested load finishes.
// - status bit 17 shows negotiation in progress, reset zero.
module vcres_regs
    import vcres_pkg::*;
(
    input  wire logic            clk_sys,
    input  wire logic            nrst,
    input  wire logic            cfg_wr,
    input  wire logic            cfg_rd,
    input  wire vcres_pkg::vcres_addr_t cfg_addr,
    input  wire logic [3:0]      cfg_be,
    input  wire vcres_pkg::vcres_word_t cfg_wdata,
    output vcres_pkg::vcres_word_t      cfg_rdata,
    input  wire logic            map_default_load,
    input  wire logic [7:0]      map_default_value,
    input  wire logic            slots_default_load,
    input  wire logic [6:0]      slots_default_value,
    input  wire logic            table_entry_wr,
    input  wire logic            table_load_done,
    input  wire logic            negotiation_pending,
    output logic [7:0]           traffic_class_channel_map,
    output vcres_pkg::vcres_arb_sel_e   arb_select,
    output logic                 channel_enable,
    output logic [2:0]           channel_identifier,
    output logic                 table_load_pulse,
    output logic                 table_load_busy
);
    import vcres_pkg::*;

    // ------------------------------------------------------------
    // state
    // ------------------------------------------------------------
    logic [7:0]     map_reg, map_next;
    logic [2:0]     sel_reg, sel_next;
    logic           en_reg, en_next;
    logic [6:0]     slots_reg, slots_next;
    logic           neg_reg, neg_next;
    vcres_word_t    rdata_reg, rdata_next;
    vcres_arb_sel_e sel_filtered;
    logic           table_status;
    logic           ctl_hit;

    function automatic vcres_word_t cap_word(input logic [6:0] slots);
        vcres_word_t w;
        w = 32'h0000_0000;
        w[7:0] = `VCRES_ARB_CAP_RESET;
        w[`VCRES_CAP_APS_BIT] = 1'b0;
        w[`VCRES_CAP_SNOOP_BIT] = 1'b0;
        w[`VCRES_CAP_SLOTS_LSB +: 7] = slots;
        w[`VCRES_CAP_OFS_LSB +: 8] = `VCRES_TABLE_OFS_RESET;
        return w;
    endfunction

    assign ctl_hit = cfg_wr && (cfg_addr == `VCRES_CTL_OFFSET);

    vcres_sel_filter u_sel (
        .sel_in  (cfg_wdata[`VCRES_CTL_SEL_LSB +: 3]),
        .sel_out (sel_filtered)
    );

    // ------------------------------------------------------------
    // next values
    // ------------------------------------------------------------
    always_comb begin
        map_next   = map_reg;
        sel_next   = sel_reg;
        en_next    = en_reg;
        slots_next = slots_reg;
        neg_next   = negotiation_pending;
        if (map_default_load) begin
            map_next = map_default_value;
        end
        if (slots_default_load) begin
            slots_next = slots_default_value;
        end
        if (ctl_hit && cfg_be[0]) begin
            map_next = cfg_wdata[7:0];
        end
        if (ctl_hit && cfg_be[2]) begin
            sel_next = 3'(sel_filtered);
        end
        if (ctl_hit && cfg_be[3]) begin
            en_next = cfg_wdata[`VCRES_CTL_EN_BIT];
        end
        rdata_next = 32'h0000_0000;
        if (cfg_rd) begin
            unique case (cfg_addr)
                `VCRES_CAP_OFFSET: rdata_next = cap_word(slots_reg);
                `VCRES_CTL_OFFSET: begin
                    rdata_next[7:0] = map_reg;
                    rdata_next[`VCRES_CTL_LOAD_BIT] = 1'b0;
                    rdata_next[`VCRES_CTL_SEL_LSB +: 3] = sel_reg;
                    rdata_next[`VCRES_CTL_ID_LSB +: 3] =
                        `VCRES_CHANNEL_ID;
                    rdata_next[`VCRES_CTL_EN_BIT] = en_reg;
                end
                `VCRES_STS_OFFSET: begin
                    rdata_next[`VCRES_STS_TABLE_BIT] = table_status;
                    rdata_next[`VCRES_STS_NEG_BIT] = neg_reg;
                end
                default: rdata_next = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
            map_reg   <= `VCRES_MAP_RESET;
            sel_reg   <= 3'h0;
            en_reg    <= `VCRES_ENABLE_RESET;
            slots_reg <= `VCRES_TIME_SLOTS_RESET;
            neg_reg   <= 1'b0;
            rdata_reg <= 32'h0000_0000;
        end else begin
            map_reg   <= map_next;
            sel_reg   <= sel_next;
            en_reg    <= en_next;
            slots_reg <= slots_next;
            neg_reg   <= neg_next;
            rdata_reg <= rdata_next;
        end
    end

    // ------------------------------------------------------------
    // load request and table status
    // ------------------------------------------------------------
    assign table_load_pulse = ctl_hit && cfg_be[2]
                              && cfg_wdata[`VCRES_CTL_LOAD_BIT];

    vcres_table_tracker u_trk (
        .clk_sys        (clk_sys),
        .nrst           (nrst),
        .table_entry_wr (table_entry_wr),
        .load_pulse     (table_load_pulse),
        .load_done      (table_load_done),
        .table_status   (table_status),
        .load_busy      (table_load_busy)
    );

    assign cfg_rdata                 = rdata_reg;
    assign traffic_class_channel_map = map_reg;
    assign arb_select                = vcres_arb_sel_e'(sel_reg);
    assign channel_enable            = en_reg;
    assign channel_identifier        = `VCRES_CHANNEL_ID;
endmodule

// File: test/vcres_arb_model.sv
`timescale 1ns/100ps
module vcres_arb_model (
    input  wire logic       clk_sys,
    input  wire logic       nrst,
    input  wire logic       load_req,
    input  wire logic [3:0] lat,
    output logic            load_done
);
    logic [3:0] cnt_reg;
    logic [3:0] cnt_next;
    assign cnt_next = load_req ? lat : cnt_reg - 4'(cnt_reg != 4'h0);
    // answers a load request after lat cycles
    always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) {cnt_reg, load_done} <= 5'h0;
        else {cnt_reg, load_done} <= {cnt_next, cnt_reg == 4'h1};
    end
endmodule

// File: test/vcres_regs_chk.sv
`timescale 1ns/100ps
module vcres_regs_chk
    import vcres_pkg::*;
(
    input wire logic                      clk_sys,
    input wire logic                      nrst,
    input wire logic                      cfg_wr,
    input wire logic                      cfg_rd,
    input wire vcres_pkg::vcres_addr_t    cfg_addr,
    input wire logic [3:0]                cfg_be,
    input wire vcres_pkg::vcres_word_t    cfg_wdata,
    input wire vcres_pkg::vcres_word_t    cfg_rdata,
    input wire logic                      negotiation_pending,
    input wire logic                      table_load_done,
    input wire logic [7:0]                traffic_class_channel_map,
    input wire vcres_pkg::vcres_arb_sel_e arb_select,
    input wire logic                      channel_enable,
    input wire logic                      table_load_pulse,
    input wire logic                      table_load_busy
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!nrst);
    wire ctl_wr = cfg_wr && cfg_addr == 12'h154;
    a_cap_fixed: assert property (cfg_rd && cfg_addr == 12'h150
        |=> (cfg_rdata & 32'hff80ffff) == 32'h04000009) else $error("cap");
    a_ctl_rsvd: assert property (cfg_rd && cfg_addr == 12'h154
        |=> (cfg_rdata & 32'h7ff1ff00) == 32'h0) else $error("ctl bits");
    a_sel_filter: assert property (ctl_wr && cfg_be[2] |=>
        arb_select == ((($past(cfg_wdata) & 32'he0000) == 32'h60000)
        ? VCRES_ARB_WRR128 : VCRES_ARB_HW_FIXED))
        else $error("select");
    a_map_write: assert property (ctl_wr && cfg_be[0] |=>
        traffic_class_channel_map == 8'($past(cfg_wdata))) else $error("map");
    a_en_write: assert property (ctl_wr && cfg_be[3] |=>
        channel_enable == $past(cfg_wdata[31])) else $error("enable");
    a_load_req: assert property (ctl_wr && cfg_be[2] && cfg_wdata[16]
        |-> table_load_pulse ##1 table_load_busy) else $error("load");
    a_busy_clear: assert property (table_load_busy && table_load_done
        && !table_load_pulse |=> !table_load_busy) else $error("busy");
    a_sts_bits: assert property (cfg_rd && cfg_addr == 12'h158 &&
        $stable(negotiation_pending) |=> (cfg_rdata & 32'hfffcffff) == 0
        && cfg_rdata[17] == $past(negotiation_pending)) else $error("status");
    c_load: cover property (table_load_busy && table_load_done);
    c_sel3: cover property (ctl_wr && cfg_wdata[19:17] == 3'h3);
    c_neg: cover property (cfg_rd && negotiation_pending);
endmodule
bind vcres_regs vcres_regs_chk CHK (.*);

// File: test/tb.sv
`timescale 1ns/100ps
module tb;
    import vcres_pkg::*;
    logic           clk_sys = 1'b0;
    logic           nrst, cfg_wr, cfg_rd, channel_enable, negotiation_pending;
    logic           map_default_load, slots_default_load, table_entry_wr;
    logic           table_load_done, table_load_pulse, table_load_busy;
    logic [2:0]     channel_identifier;
    logic [3:0]     cfg_be, lat;
    logic [6:0]     slots_default_value;
    logic [7:0]     map_default_value, traffic_class_channel_map;
    logic [11:0]    cfg_addr;
    logic [31:0]    cfg_wdata, cfg_rdata;
    vcres_arb_sel_e arb_select;
    int             n_mismatch = 0, check_count = 0, cycles = 0, n_pulse = 0;
    vcres_regs DUT (.*);
    vcres_arb_model ARB (.clk_sys(clk_sys), .nrst(nrst), .lat(lat),
        .load_req(table_load_pulse), .load_done(table_load_done));
    initial forever #4 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        n_pulse += int'(table_load_pulse === 1'b1);
        cycles++;
        if (cycles == 3000) begin
            n_mismatch++;
            results();
        end
    end
    task automatic chk(input logic [31:0] s, input logic [31:0] e);
        check_count++;
        n_mismatch += int'(s !== e);
        if (s !== e) $display("Error at %0t: got %h want %h", $time, s, e);
    endtask
    task automatic acc(input logic w, logic [11:0] a, logic [3:0] b,
                       logic [31:0] d);
        @(posedge clk_sys);
        #1;
        {cfg_wr, cfg_rd, cfg_addr, cfg_be, cfg_wdata} = {w, !w, a, b, d};
        @(posedge clk_sys);
        #1;
        {cfg_wr, cfg_rd} = 2'h0;
        if (!w) chk(cfg_rdata, d);
    endtask
    task automatic results();
        if (n_mismatch == 0 && check_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        logic [31:0] s;
        {nrst, cfg_wr, cfg_rd, map_default_load, slots_default_load} = 5'h0;
        {cfg_addr, cfg_be, cfg_wdata, lat} = 52'h6;
        {table_entry_wr, negotiation_pending, map_default_value,
         slots_default_value} = 17'h1e12;
        repeat (4) @(posedge clk_sys);
        #1;
        nrst = 1'b1;
        acc(0, 12'h150, 4'h0, 32'h047f0009);
        acc(0, 12'h154, 4'h0, 32'h800000ff);
        acc(1, 12'h150, 4'hf, 32'hffffffff);
        acc(0, 12'h150, 4'h0, 32'h047f0009);
        for (int v = 0; v < 8; v++) begin
            s = (v == 3) ? 32'h00060000 : 32'h0;
            acc(1, 12'h154, 4'hf, 32'hfff0ffa5 | 32'(v << 17));
            acc(0, 12'h154, 4'h0, 32'h800000a5 | s);
            chk({29'h0, arb_select}, s >> 17);
        end
        acc(1, 12'h154, 4'h8, 32'h0);
        {map_default_load, slots_default_load, table_entry_wr} = 3'h7;
        acc(0, 12'h15c, 4'h0, 32'h0);
        {map_default_load, slots_default_load, table_entry_wr} = 3'h0;
        acc(0, 12'h150, 4'h0, 32'h04120009);
        acc(0, 12'h154, 4'h0, 32'h0000003c);
        chk({23'h0, channel_enable, traffic_class_channel_map}, 32'h3c);
        chk({29'h0, channel_identifier}, 32'h0);
        acc(0, 12'h158, 4'h0, 32'h00010000);
        acc(1, 12'h154, 4'h4, 32'h00010000);
        chk(n_pulse, 32'h1);
        acc(0, 12'h158, 4'h0, 32'h00010000);
        for (int i = 0; i < 20 && table_load_busy; i++) @(posedge clk_sys);
        #1;
        negotiation_pending = 1'b1;
        acc(0, 12'h158, 4'h0, 32'h00020000);
        acc(0, 12'h154, 4'h0, 32'h0000003c);
        results();
    end
endmodule
